// ===== rtl/gdr_pkg.sv
// gdr_pkg: shared constants and types for the host response logic
package gdr_pkg;

   // request/response message identifiers (low six bits)
   localparam int ID_W = 6;
   localparam logic [5:0] ID_SET_CFG = 6'h01;
   localparam logic [5:0] ID_GET_CFG = 6'h02;
   localparam logic [5:0] ID_SET_REF = 6'h03;
   localparam logic [5:0] ID_GET_REF = 6'h04;
   localparam logic [5:0] ID_SUP = 6'h05;
   localparam logic [5:0] ID_DRV = 6'h06;

   // first byte kind in bits 7:6
   localparam logic [1:0] KIND_NAK = 2'h0;
   localparam logic [1:0] KIND_ACK = 2'h1;
   localparam logic [1:0] KIND_UNSOL = 2'h2;
   localparam int REQ_BIT = 7;
   localparam int ACK_BIT = 6;

   // setup byte fields
   localparam int CFG_RSV = 7;
   localparam int CFG_PU = 6;
   localparam int CFG_SLEEP = 5;
   localparam int CFG_NEU = 4;
   localparam int CFG_XUV = 3;
   localparam int CFG_XOC = 2;
   localparam int CFG_OC_HI = 1;
   localparam int CFG_OC_LO = 0;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] REF_RST = 8'h40;

   // driver fault byte fields
   localparam int DRV_XUV = 2;
   localparam int DRV_XOC = 3;
   localparam int DRV_BOR = 4;
   localparam int DRV_LDO = 5;
   // driver fault pins: [0] ext lockout, [1] ext overcurrent, [2] 5v lockout
   localparam int DPIN_W = 3;

   typedef enum logic [1:0] {
      ST_IDLE, ST_DATA, ST_SEND1, ST_SEND2
   } gdr_st_e;

   typedef struct packed {
      logic pullup_disconnect;
      logic sleep_mode;
      logic standby_mode;
      logic neutral_sim_en;
      logic ext_low_supply_lockout_en;
      logic ext_oc_en;
      logic [1:0] ext_oc_sel;
      logic [7:0] limit_ref;
   } gdr_ctrl_s;

   typedef struct packed {
      gdr_st_e st;
      logic [5:0] id;
      logic [7:0] tx_byte;
      logic [7:0] data2;
      logic has2;
      logic [7:0] cfg0;
      logic [7:0] lref;
      logic bor;
      logic [7:0] sup1;
      logic [7:0] sup2;
      logic [7:0] sup3;
      logic [7:0] sup_f;
      logic [DPIN_W-1:0] drv1;
      logic [DPIN_W-1:0] drv2;
      logic [DPIN_W-1:0] drv3;
      logic [DPIN_W-1:0] drv_f;
      logic [2:0] ce_s;
      logic ce_f;
      logic pend_sup;
      logic pend_drv;
      gdr_ctrl_s ctrl;
   } gdr_state_s;

endpackage

// ===== rtl/gdr_host_resp.sv
// gdr_host_resp: answers host requests and sends fault reports
// Function
// - setup write answered 01H on reject, 41H on accept
// - setup read answered 02H or 42H, then current setup byte
// - limit write answered 03H or 43H, then reference code
// - limit read answered 04H or 44H, then stored reference code
// - supply report request answered 05H or 45H, then status byte
// - supply report may be sent unasked as 85H plus status byte
// - driver report uses 06H reject, 46H acknowledge, 86H unasked
// - setup bit 6 keeps pull-up connected while enable low; ignored in sleep
// - setup bit 5 picks standby or sleep; sleep always disconnects pull-up
// - setup bit 4 enables neutral simulator, start-up value 0
// - setup bit 3 at 1 turns off external transistor lockout
// - setup bit 2 at 1 turns off external overcurrent detection
// - setup bits 1:0 pick overcurrent threshold; bit 7 reads 0
// - reference code uses all eight bits, 00H to FFH
// - supply byte bits 5,6,7: buck overcurrent, warning, brown-out
// - supply byte bits 0-4: temperature, overtemp, input under/overvoltage
// - driver byte bits 2,3,5 carry faults; bits 0,1,6,7 read 0
// - driver byte bit 4 flags lost configuration, 1 after start-up
// - reference code is 40H after start-up until written
// - pull-up control bit changes only in standby
module gdr_host_resp
   import gdr_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic [7:0] supply_flag_pins,
   input wire logic [DPIN_W-1:0] driver_flag_pins,
   input wire logic chip_enable_pin,
   output gdr_ctrl_s ctrl
);

   function automatic logic [7:0] mk_op(
      input logic [1:0] kind,
      input logic [5:0] id
   );
      mk_op = {kind, id};
   endfunction

   function automatic logic [7:0] drv_byte(
      input logic [DPIN_W-1:0] f,
      input logic bor
   );
      logic [7:0] b;
      b = 8'h00;
      b[DRV_XUV] = f[0];
      b[DRV_XOC] = f[1];
      b[DRV_LDO] = f[2];
      b[DRV_BOR] = bor;
      drv_byte = b;
   endfunction

   localparam gdr_state_s RST_STATE = '{
      st: ST_IDLE,
      id: '0,
      tx_byte: '0,
      data2: '0,
      has2: 1'b0,
      cfg0: CFG_RST,
      lref: REF_RST,
      bor: 1'b1,
      sup1: '0,
      sup2: '0,
      sup3: '0,
      sup_f: '0,
      drv1: '0,
      drv2: '0,
      drv3: '0,
      drv_f: '0,
      ce_s: '0,
      ce_f: 1'b0,
      pend_sup: 1'b0,
      pend_drv: 1'b0,
      ctrl: '{
         pullup_disconnect: 1'b1,
         sleep_mode: 1'b0,
         standby_mode: 1'b1,
         neutral_sim_en: 1'b0,
         ext_low_supply_lockout_en: 1'b1,
         ext_oc_en: 1'b1,
         ext_oc_sel: 2'h0,
         limit_ref: REF_RST
      }
   };

   gdr_state_s r_r;
   gdr_state_s r_nxt;
   logic sup_chg;
   logic drv_chg;
   logic standby;
   logic pu_ok;

   assign rx_ready = (r_r.st == ST_IDLE) || (r_r.st == ST_DATA);
   assign tx_valid = (r_r.st == ST_SEND1) || (r_r.st == ST_SEND2);
   assign tx_byte = r_r.tx_byte;
   assign ctrl = r_r.ctrl;

   always_comb begin
      r_nxt = r_r;
      // pin synchronisers: a change counts when stages two and three agree
      r_nxt.sup1 = supply_flag_pins;
      r_nxt.sup2 = r_r.sup1;
      r_nxt.sup3 = r_r.sup2;
      if (r_r.sup2 == r_r.sup3) begin
         r_nxt.sup_f = r_r.sup3;
      end
      r_nxt.drv1 = driver_flag_pins;
      r_nxt.drv2 = r_r.drv1;
      r_nxt.drv3 = r_r.drv2;
      if (r_r.drv2 == r_r.drv3) begin
         r_nxt.drv_f = r_r.drv3;
      end
      r_nxt.ce_s = {r_r.ce_s[1:0], chip_enable_pin};
      if (r_r.ce_s[1] == r_r.ce_s[2]) begin
         r_nxt.ce_f = r_r.ce_s[2];
      end
      // a flag change arms an unasked report; a new change beats the clear
      sup_chg = r_nxt.sup_f != r_r.sup_f;
      drv_chg = r_nxt.drv_f != r_r.drv_f;
      if (sup_chg) begin
         r_nxt.pend_sup = 1'b1;
      end
      if (drv_chg) begin
         r_nxt.pend_drv = 1'b1;
      end
      standby = !r_r.ce_f && !r_r.cfg0[CFG_SLEEP];
      pu_ok = (rx_byte[CFG_PU] == r_r.cfg0[CFG_PU]) || standby;
      case (r_r.st)
         ST_IDLE: begin
            if (rx_valid && rx_byte[REQ_BIT]) begin
               r_nxt.id = rx_byte[ID_W-1:0];
               r_nxt.st = ST_SEND1;
               r_nxt.has2 = 1'b1;
               r_nxt.tx_byte = mk_op(KIND_ACK, rx_byte[ID_W-1:0]);
               // bit 6 of a request is never set by a valid code
               if (rx_byte[ACK_BIT]) begin
                  r_nxt.tx_byte = mk_op(KIND_NAK, rx_byte[ID_W-1:0]);
                  r_nxt.has2 = 1'b0;
               end else begin
                  case (rx_byte[ID_W-1:0])
                     ID_SET_CFG, ID_SET_REF: begin
                        r_nxt.st = ST_DATA;
                     end
                     ID_GET_CFG: begin
                        r_nxt.data2 = r_r.cfg0;
                     end
                     ID_GET_REF: begin
                        r_nxt.data2 = r_r.lref;
                     end
                     ID_SUP: begin
                        r_nxt.data2 = r_r.sup_f;
                        r_nxt.pend_sup = sup_chg;
                     end
                     ID_DRV: begin
                        r_nxt.data2 = drv_byte(r_r.drv_f, r_r.bor);
                        r_nxt.pend_drv = drv_chg;
                     end
                     default: begin
                        r_nxt.tx_byte = mk_op(KIND_NAK, rx_byte[ID_W-1:0]);
                        r_nxt.has2 = 1'b0;
                     end
                  endcase
               end
            end else if (r_r.pend_sup) begin
               r_nxt.id = ID_SUP;
               r_nxt.tx_byte = mk_op(KIND_UNSOL, ID_SUP);
               r_nxt.data2 = r_r.sup_f;
               r_nxt.has2 = 1'b1;
               r_nxt.pend_sup = sup_chg;
               r_nxt.st = ST_SEND1;
            end else if (r_r.pend_drv) begin
               r_nxt.id = ID_DRV;
               r_nxt.tx_byte = mk_op(KIND_UNSOL, ID_DRV);
               r_nxt.data2 = drv_byte(r_r.drv_f, r_r.bor);
               r_nxt.has2 = 1'b1;
               r_nxt.pend_drv = drv_chg;
               r_nxt.st = ST_SEND1;
            end
         end
         ST_DATA: begin
            if (rx_valid) begin
               r_nxt.st = ST_SEND1;
               r_nxt.has2 = 1'b1;
               if (r_r.id == ID_SET_REF) begin
                  r_nxt.lref = rx_byte;
                  r_nxt.data2 = rx_byte;
                  r_nxt.tx_byte = mk_op(KIND_ACK, ID_SET_REF);
               end else if (!rx_byte[CFG_RSV] && pu_ok) begin
                  r_nxt.cfg0 = rx_byte;
                  r_nxt.data2 = rx_byte;
                  r_nxt.tx_byte = mk_op(KIND_ACK, ID_SET_CFG);
               end else begin
                  r_nxt.tx_byte = mk_op(KIND_NAK, ID_SET_CFG);
                  r_nxt.has2 = 1'b0;
               end
            end
         end
         ST_SEND1: begin
            if (tx_ready) begin
               r_nxt.st = r_r.has2 ? ST_SEND2 : ST_IDLE;
               r_nxt.tx_byte = r_r.data2;
            end
         end
         ST_SEND2: begin
            if (tx_ready) begin
               r_nxt.st = ST_IDLE;
               // lost-config flag clears once the driver byte is delivered
               if (r_r.id == ID_DRV) begin
                  r_nxt.bor = 1'b0;
               end
            end
         end
         default: begin
            r_nxt.st = ST_IDLE;
         end
      endcase
      r_nxt.ctrl.sleep_mode = !r_nxt.ce_f && r_nxt.cfg0[CFG_SLEEP];
      r_nxt.ctrl.standby_mode = !r_nxt.ce_f && !r_nxt.cfg0[CFG_SLEEP];
      r_nxt.ctrl.pullup_disconnect = !r_nxt.ce_f &&
         (r_nxt.cfg0[CFG_SLEEP] || !r_nxt.cfg0[CFG_PU]);
      r_nxt.ctrl.neutral_sim_en = r_nxt.cfg0[CFG_NEU];
      r_nxt.ctrl.ext_low_supply_lockout_en = !r_nxt.cfg0[CFG_XUV];
      r_nxt.ctrl.ext_oc_en = !r_nxt.cfg0[CFG_XOC];
      r_nxt.ctrl.ext_oc_sel = r_nxt.cfg0[CFG_OC_HI:CFG_OC_LO];
      r_nxt.ctrl.limit_ref = r_nxt.lref;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_r <= RST_STATE;
      end else begin
         r_r <= r_nxt;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   logic idle_req;
   assign idle_req = r_r.st == ST_IDLE && rx_valid && rx_byte[REQ_BIT];

   sequence set_req(logic [7:0] code);
      idle_req && rx_byte == code ##1 r_r.st == ST_DATA && rx_valid;
   endsequence

   sequence answer(logic [7:0] op);
      r_r.st == ST_SEND1 && tx_byte == op;
   endsequence

   set_ref_a: assert property (
      set_req(mk_op(KIND_UNSOL, ID_SET_REF)) |=>
         answer(mk_op(KIND_ACK, ID_SET_REF)) && r_r.data2 == r_r.lref)
      else $error("limit write not acknowledged with its code");

   get_ref_a: assert property (
      idle_req && rx_byte == mk_op(KIND_UNSOL, ID_GET_REF) |=>
         answer(mk_op(KIND_ACK, ID_GET_REF)) && r_r.data2 == $past(r_r.lref))
      else $error("limit read answer wrong");

   get_cfg_a: assert property (
      idle_req && rx_byte == mk_op(KIND_UNSOL, ID_GET_CFG) |=>
         answer(mk_op(KIND_ACK, ID_GET_CFG)) ##0 r_r.has2)
      else $error("setup read answer wrong");

   cfg_guard_a: assert property (
      $changed(r_r.cfg0) |->
         $past(r_r.st) == ST_DATA && $past(r_r.id) == ID_SET_CFG &&
         tx_byte == mk_op(KIND_ACK, ID_SET_CFG))
      else $error("setup changed without accepted write");

   pu_standby_a: assert property (
      $changed(r_r.cfg0[CFG_PU]) |-> $past(r_r.ctrl.standby_mode))
      else $error("pull-up bit changed outside standby");

   cfg_rsv_a: assert property (
      r_r.cfg0[CFG_RSV] == 1'b0)
      else $error("setup reserved bit set");

   nak_single_a: assert property (
      r_r.st == ST_SEND1 && tx_byte[7:6] == KIND_NAK && tx_ready |=>
         r_r.st == ST_IDLE)
      else $error("reject answer carried a second byte");

   unsol_sup_a: assert property (
      r_r.st == ST_IDLE && r_r.pend_sup && !idle_req |=>
         answer(mk_op(KIND_UNSOL, ID_SUP)) ##0 r_r.data2 == $past(r_r.sup_f))
      else $error("unasked supply report malformed");

   bor_clear_a: assert property (
      $fell(r_r.bor) |->
         $past(r_r.st) == ST_SEND2 && $past(r_r.id) == ID_DRV)
      else $error("lost-config flag cleared before report");

   pullup_a: assert property (
      r_r.ctrl.pullup_disconnect == (!r_r.ce_f &&
         (r_r.cfg0[CFG_SLEEP] || !r_r.cfg0[CFG_PU])))
      else $error("pull-up control mismatch");

   sleep_pu_a: assert property (
      r_r.ctrl.sleep_mode |-> r_r.ctrl.pullup_disconnect)
      else $error("sleep left pull-up connected");

   set_cfg_a: assert property (
      set_req(mk_op(KIND_UNSOL, ID_SET_CFG)) |=> r_r.st == ST_SEND1 &&
         ((tx_byte == mk_op(KIND_ACK, ID_SET_CFG) &&
         r_r.data2 == r_r.cfg0) ||
         (tx_byte == mk_op(KIND_NAK, ID_SET_CFG) && !r_r.has2 &&
         $stable(r_r.cfg0))))
      else $error("setup write answer wrong");

   get_sup_a: assert property (
      idle_req && rx_byte == mk_op(KIND_UNSOL, ID_SUP) |=>
         answer(mk_op(KIND_ACK, ID_SUP)) ##0 r_r.data2 == $past(r_r.sup_f))
      else $error("supply report answer wrong");

   get_drv_a: assert property (
      idle_req && rx_byte == mk_op(KIND_UNSOL, ID_DRV) |=>
         answer(mk_op(KIND_ACK, ID_DRV)) ##0
         r_r.data2[DRV_BOR] == $past(r_r.bor) &&
         r_r.data2[DRV_XUV] == $past(r_r.drv_f[0]))
      else $error("driver report answer wrong");

   drv_rsv_a: assert property (
      r_r.st == ST_SEND2 && r_r.id == ID_DRV |->
         tx_byte[DRV_XUV-1:0] == '0 && tx_byte[REQ_BIT:ACK_BIT] == '0)
      else $error("driver report reserved bit set");

   unsol_drv_a: assert property (
      r_r.st == ST_IDLE && !r_r.pend_sup && r_r.pend_drv && !idle_req |=>
         answer(mk_op(KIND_UNSOL, ID_DRV)))
      else $error("unasked driver report malformed");

   nak_id_a: assert property (
      idle_req && rx_byte[ACK_BIT] |=> r_r.st == ST_SEND1 && !r_r.has2 &&
         tx_byte[REQ_BIT:ACK_BIT] == KIND_NAK &&
         tx_byte[ID_W-1:0] == $past(rx_byte[ID_W-1:0]))
      else $error("reject answer lost its identifier");

endmodule // gdr_host_resp

// ===== bench/gdr_host_model.sv
// gdr_host_model: host side of the byte link, sends requests, takes answers
module gdr_host_model
   import gdr_pkg::*;
(
   input wire logic clock,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   int stall;

   initial begin
      stall = 0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end

   // byte held until taken; then the line is released and shows the
   // inverse value, unless another byte follows straight away
   task automatic put(input logic [7:0] b, input bit more);
      int n;
      n = 0;
      if (rx_valid !== 1'b1) begin
         @(negedge clock);
      end
      rx_valid = 1'b1;
      rx_byte = b;
      while (rx_ready !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      @(negedge clock);
      if (!more) begin
         rx_valid = 1'b0;
         rx_byte = ~b;
      end
   endtask

   // wait for an offered byte, optionally stall, then take it; ready
   // stays low for a full cycle between two bytes
   task automatic get(output logic [7:0] b);
      int n;
      n = 0;
      @(negedge clock);
      while (tx_valid !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      repeat (stall) @(negedge clock);
      tx_ready = 1'b1;
      b = tx_byte;
      @(posedge clock);
      @(negedge clock);
      tx_ready = 1'b0;
   endtask

endmodule // gdr_host_model

// ===== bench/gdr_host_resp_tb.sv
// gdr_host_resp_tb: self-checking bench for the host response logic
module gdr_host_resp_tb;
   import gdr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock, rstn, rx_valid, rx_ready, tx_valid, tx_ready;
   logic chip_enable_pin;
   logic [7:0] rx_byte, tx_byte, supply_flag_pins;
   logic [DPIN_W-1:0] driver_flag_pins;
   gdr_ctrl_s ctrl;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] dmap [3] = '{8'h04, 8'h08, 8'h20};

   gdr_host_resp gdr_host_resp_i (
      .clock(clock),
      .rstn(rstn),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .rx_ready(rx_ready),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready),
      .supply_flag_pins(supply_flag_pins),
      .driver_flag_pins(driver_flag_pins),
      .chip_enable_pin(chip_enable_pin),
      .ctrl(ctrl)
   );

   gdr_host_model gdr_host_model_i (
      .clock(clock),
      .rx_ready(rx_ready),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .tx_ready(tx_ready)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one or two answer bytes, then the link must go quiet
   task automatic answer(input int n, input logic [7:0] e0,
                         input logic [7:0] e1);
      logic [7:0] b;
      gdr_host_model_i.get(b);
      chk("opcode", b, e0);
      if (n == 2) begin
         chk("rx_ready", {7'h00, rx_ready}, 8'h00);
         gdr_host_model_i.get(b);
         chk("data", b, e1);
      end
      chk("tx_valid", {7'h00, tx_valid}, 8'h00);
      chk("rx_ready", {7'h00, rx_ready}, 8'h01);
   endtask

   task automatic req(input logic [7:0] cmd, input bit wr,
                      input logic [7:0] d, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
      gdr_host_model_i.put(cmd, wr);
      if (wr) begin
         gdr_host_model_i.put(d, 1'b0);
      end
      answer(n, e0, e1);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      rstn = 1'b0;
      chip_enable_pin = 1'b0;
      supply_flag_pins = 8'h00;
      driver_flag_pins = '0;
      repeat (6) @(negedge clock);
      chk("pullup", {7'h00, ctrl.pullup_disconnect}, 8'h01);
      rstn = 1'b1;
      chk("standby", {7'h00, ctrl.standby_mode}, 8'h01);
      chk("neutral", {7'h00, ctrl.neutral_sim_en}, 8'h00);
      chk("low_supply_lockout_en", {7'h00, ctrl.ext_low_supply_lockout_en}, 8'h01);
      chk("oc_en", {7'h00, ctrl.ext_oc_en}, 8'h01);
      chk("oc_sel", {6'h00, ctrl.ext_oc_sel}, 8'h00);
      chk("limit", ctrl.limit_ref, 8'h40);
      repeat (6) @(negedge clock);
      req(8'h86, 0, 8'h00, 2, 8'h46, 8'h10);
      req(8'h86, 0, 8'h00, 2, 8'h46, 8'h00);
      req(8'h82, 0, 8'h00, 2, 8'h42, 8'h00);
      req(8'h84, 0, 8'h00, 2, 8'h44, 8'h40);
      req(8'h85, 0, 8'h00, 2, 8'h45, 8'h00);
      req(8'h83, 1, 8'hff, 2, 8'h43, 8'hff);
      req(8'h84, 0, 8'h00, 2, 8'h44, 8'hff);
      chk("limit", ctrl.limit_ref, 8'hff);
      // write whose data byte comes two cycles after the command
      gdr_host_model_i.put(8'h83, 1'b0);
      gdr_host_model_i.put(8'h00, 1'b0);
      answer(2, 8'h43, 8'h00);
      for (int k = 0; k < 4; k++) begin
         req(8'h81, 1, 8'h1c | k[7:0], 2, 8'h41, 8'h1c | k[7:0]);
         chk("oc_sel", {6'h00, ctrl.ext_oc_sel}, k[7:0]);
      end
      chk("neutral", {7'h00, ctrl.neutral_sim_en}, 8'h01);
      chk("low_supply_lockout_en", {7'h00, ctrl.ext_low_supply_lockout_en}, 8'h00);
      chk("oc_en", {7'h00, ctrl.ext_oc_en}, 8'h00);
      req(8'h81, 1, 8'h9f, 1, 8'h01, 8'h00);
      req(8'h82, 0, 8'h00, 2, 8'h42, 8'h1f);
      for (int k = 1; k < 7; k++) begin
         req(8'hc0 | k[7:0], 0, 8'h00, 1, k[7:0], 8'h00);
      end
      req(8'h87, 0, 8'h00, 1, 8'h07, 8'h00);
      // a byte without the request bit starts nothing
      gdr_host_model_i.put(8'h02, 1'b0);
      repeat (4) @(negedge clock);
      chk("ignored", {7'h00, tx_valid}, 8'h00);
      // pull-up control may only move while in standby
      chip_enable_pin = 1'b1;
      repeat (6) @(negedge clock);
      chk("standby", {7'h00, ctrl.standby_mode}, 8'h00);
      req(8'h81, 1, 8'h40, 1, 8'h01, 8'h00);
      chip_enable_pin = 1'b0;
      repeat (6) @(negedge clock);
      req(8'h81, 1, 8'h40, 2, 8'h41, 8'h40);
      chk("pullup", {7'h00, ctrl.pullup_disconnect}, 8'h00);
      req(8'h81, 1, 8'h60, 2, 8'h41, 8'h60);
      chk("sleep", {7'h00, ctrl.sleep_mode}, 8'h01);
      chk("pullup", {7'h00, ctrl.pullup_disconnect}, 8'h01);
      req(8'h81, 1, 8'h00, 1, 8'h01, 8'h00);
      req(8'h81, 1, 8'h40, 2, 8'h41, 8'h40);
      // unasked reports taken by a slow host
      gdr_host_model_i.stall = 3;
      for (int i = 0; i < 8; i++) begin
         supply_flag_pins = 8'h01 << i;
         answer(2, 8'h85, 8'h01 << i);
      end
      for (int i = 0; i < 3; i++) begin
         driver_flag_pins = 3'b001 << i;
         answer(2, 8'h86, dmap[i]);
      end
      supply_flag_pins = 8'h00;
      answer(2, 8'h85, 8'h00);
      finish_test();
   end

endmodule // gdr_host_resp_tb
